/* tsr_status_regs.sv */
`timescale 1ns/1ps
// Summary of operation
// [R1] Set protection bit 5 when output current strays over ten percent.
// [R2] Set protection bit 4 on any change of the interlock input.
// [R3] Set protection bit 3 when the 5.6 V output clamp engages.
// [R4] Set protection bit 2 when output power hits its rated limit.
// [R5] Set protection bit 1 when an output duration limit expires.
// [R6] Set protection bit 0 on abnormal internal temperature.
// [R7] Set fail bit 2 on a fail past the upper limit.
// [R8] Set fail bit 1 on a fail past the lower limit.
// [R9] Set bad setting bit 3 when settings exceed resistance range.
// [R10] Set bad setting bit 2 when settings exceed the power limit.
// [R11] Set bad setting bit 1 when lower limit exceeds upper value.
// [R12] Set bad setting bit 0 when test voltage exceeds 5.4 V.
// [R13] Set error bit 3 when an invalid device message occurs.
// [R14] Set error bit 2 on an out-of-range parameter.
// [R15] Set error bit 1 on malformed message data.
// [R16] Set error bit 0 on an unrecognised header.
// [R17] Clear-status empties all status, flag and error registers together.
// [R18] Event status query returns the register, then clears it.
// [R19] Service request enable write accepted only outside testing and protection.
// [R20] Buffer flush discards input buffer, same as device clear.
// [R21] Each command carries testing and protection acceptance flags; others rejected.
// [R22] Memo line 1 to 3, up to 20 chars 20h-7eh, four excluded.
// [R23] Set event status bit 4 on a message refused by state.
// [R24] Set event status bit 5 on syntax, data or range error.
// [R25] Unused bits of the four flag registers read zero.
// [R26] Flags stay set until a clear-status command.
module tsr_status_regs (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   // Measurement and protection conditions from pins
   input  wire logic             output_amp_deviation_in,
   input  wire logic             interlock_in,
   input  wire logic             voltage_clamp_in,
   input  wire logic             overload_trip_in,
   input  wire logic             heat_timer_trip_in,
   input  wire logic             internal_temp_trip_in,
   input  wire logic             upper_fail_in,
   input  wire logic             lower_fail_in,
   input  wire logic             ohms_range_exceeded_in,
   input  wire logic             power_limit_exceeded_in,
   input  wire logic             low_above_up_in,
   input  wire logic             test_voltage_high_in,
   // Operating state from pins
   input  wire logic             testing_in,
   input  wire logic             protection_active_in,
   // Decoded commands from the message parser
   input  wire logic             cmd_valid_in,
   input  wire tsr_pkg::tsr_cmd_t cmd_code_in,
   input  wire logic [7:0]       cmd_data_in,
   // Parser faults, one-cycle pulses
   input  wire logic             header_err_in,
   input  wire logic             data_err_in,
   input  wire logic             range_err_in,
   // Register contents
   output logic [7:0]            protection_flags_out,
   output logic [7:0]            judgment_fail_flags_out,
   output logic [7:0]            bad_setting_flags_out,
   output logic [7:0]            command_error_flags_out,
   output logic [7:0]            event_status_out,
   output logic [7:0]            srq_enable_out,
   output logic [7:0]            status_byte_out,
   // Query answer
   output logic                  resp_valid_out,
   output logic [7:0]            resp_data_out,
   // Command outcome
   output logic                  run_state_reject_out,
   output logic                  input_buffer_flush_out
);
   import tsr_pkg::*;

   localparam int unsigned NPIN = 14;

   typedef struct packed {
      logic [7:0] prot;
      logic [7:0] fail;
      logic [7:0] bad;
      logic [7:0] err;
      logic [7:0] esr;
      logic [7:0] sre;
      logic [7:0] stb;
      logic       ilock_prev;
      logic [1:0] ilock_arm;
      logic       resp_valid;
      logic [7:0] resp_data;
      logic       reject;
      logic       flush;
   } tsr_state_t;

   tsr_state_t q;
   tsr_state_t d;

   logic [NPIN-1:0] pin_sync;
   logic            memo_range_err;
   logic            memo_data_err;
   logic            accepted;
   logic            rejected;
   logic            memo_sel;
   logic            memo_char;

   // Availability while a test runs
   function automatic logic tsr_ok_testing(input tsr_cmd_t c);
      case (c)
         TSR_CMD_SRE_W,
         TSR_CMD_MEMO_SEL,
         TSR_CMD_MEMO_CHAR,
         TSR_CMD_OTHER_SET: tsr_ok_testing = 1'b0;
         default:           tsr_ok_testing = 1'b1;
      endcase
   endfunction : tsr_ok_testing

   // Availability while protection is active
   function automatic logic tsr_ok_protect(input tsr_cmd_t c);
      case (c)
         TSR_CMD_SRE_W,
         TSR_CMD_MEMO_SEL,
         TSR_CMD_MEMO_CHAR,
         TSR_CMD_OTHER_SET: tsr_ok_protect = 1'b0;
         default:           tsr_ok_protect = 1'b1;
      endcase
   endfunction : tsr_ok_protect

   tsr_sync #(
      .W(NPIN)
   ) u_sync (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .async_in({protection_active_in,
                 testing_in,
                 test_voltage_high_in,
                 low_above_up_in,
                 power_limit_exceeded_in,
                 ohms_range_exceeded_in,
                 lower_fail_in,
                 upper_fail_in,
                 internal_temp_trip_in,
                 heat_timer_trip_in,
                 overload_trip_in,
                 voltage_clamp_in,
                 interlock_in,
                 output_amp_deviation_in}),
      .sync_out(pin_sync)
   );

   tsr_memo_check u_memo (
      .clk_in       (clk_in),
      .rstn_in      (rstn_in),
      .sel_in       (memo_sel),
      .char_in      (memo_char),
      .data_in      (cmd_data_in),
      .range_err_out(memo_range_err),
      .data_err_out (memo_data_err)
   );

   // [R21] State acceptance check
   always_comb
   begin
      rejected = cmd_valid_in &&
                 ((pin_sync[12] && !tsr_ok_testing(cmd_code_in)) ||
                  (pin_sync[13] && !tsr_ok_protect(cmd_code_in)));
      accepted = cmd_valid_in && !rejected;
   end

   // [R22] Memo traffic goes to the checker
   assign memo_sel  = accepted && (cmd_code_in == TSR_CMD_MEMO_SEL);
   assign memo_char = accepted && (cmd_code_in == TSR_CMD_MEMO_CHAR);

   always_comb
   begin
      logic [7:0] prot_set;
      logic [7:0] fail_set;
      logic [7:0] bad_set;
      logic [7:0] err_set;
      logic [7:0] esr_set;
      logic       clear_all;
      logic       esr_read;
      logic       ilock_change;
      prot_set     = 8'h00;
      fail_set     = 8'h00;
      bad_set      = 8'h00;
      err_set      = 8'h00;
      esr_set      = 8'h00;
      clear_all    = accepted && (cmd_code_in == TSR_CMD_CLS);
      esr_read     = accepted && (cmd_code_in == TSR_CMD_ESR_Q);
      ilock_change = (q.ilock_arm == TSR_ILOCK_ARM) &&
                     (pin_sync[1] != q.ilock_prev);
      d            = q;

      // [R1] Current deviation
      prot_set[TSR_PROT_AMP_DEV] = pin_sync[0];
      // [R2] Interlock change
      prot_set[TSR_PROT_ILOCK] = ilock_change;
      // [R3] Voltage clamp
      prot_set[TSR_PROT_CLAMP] = pin_sync[2];
      // [R4] Overload trip
      prot_set[TSR_PROT_OVERLOAD] = pin_sync[3];
      // [R5] Duration limit
      prot_set[TSR_PROT_HEAT_TMR] = pin_sync[4];
      // [R6] Temperature trip
      prot_set[TSR_PROT_TEMP] = pin_sync[5];
      // [R7] Upper fail
      fail_set[TSR_FAIL_UPPER] = pin_sync[6];
      // [R8] Lower fail
      fail_set[TSR_FAIL_LOWER] = pin_sync[7];
      // [R9] Resistance range
      bad_set[TSR_BAD_OHMS] = pin_sync[8];
      // [R10] Power limit setting
      bad_set[TSR_BAD_POWER] = pin_sync[9];
      // [R11] Lower above upper
      bad_set[TSR_BAD_LOW_UP] = pin_sync[10];
      // [R12] Test voltage high
      bad_set[TSR_BAD_VOLTAGE] = pin_sync[11];
      // [R13] Invalid device message
      err_set[TSR_ERR_INVALID] = rejected;
      // [R14] Out of range
      err_set[TSR_ERR_RANGE] = range_err_in || memo_range_err;
      // [R15] Data error
      err_set[TSR_ERR_DATA] = data_err_in || memo_data_err;
      // [R16] Syntax error
      err_set[TSR_ERR_SYNTAX] = header_err_in;
      // [R23] Refused message event
      esr_set[TSR_ESR_REJECT] = rejected;
      // [R24] Command fault event
      esr_set[TSR_ESR_FAULT] = |err_set[TSR_ERR_RANGE:TSR_ERR_SYNTAX];

      // [R26] Sticky until cleared, new events win over clear
      // [R17] Clear all together
      d.prot = (clear_all ? TSR_FLAGS_RST : q.prot) | prot_set;
      d.fail = (clear_all ? TSR_FLAGS_RST : q.fail) | fail_set;
      d.bad  = (clear_all ? TSR_FLAGS_RST : q.bad)  | bad_set;
      d.err  = (clear_all ? TSR_FLAGS_RST : q.err)  | err_set;
      // [R18] Read clears event status
      d.esr  = ((clear_all || esr_read) ? TSR_FLAGS_RST : q.esr) | esr_set;

      // [R25] Unused positions forced to zero
      d.prot[7:6] = 2'h0;
      d.fail[7:3] = 5'h00;
      d.fail[0]   = 1'b0;
      d.bad[7:4]  = 4'h0;
      d.err[7:4]  = 4'h0;
      d.esr[3:0]  = 4'h0;
      d.esr[7:6]  = 2'h0;

      // [R19] Enable write only when refused neither way
      if (accepted && (cmd_code_in == TSR_CMD_SRE_W))
         d.sre = cmd_data_in;

      d.stb                = 8'h00;
      d.stb[TSR_STB_ESB]   = |d.esr;
      d.stb[TSR_STB_DSB]   = |{d.prot, d.fail, d.bad};
      d.stb[TSR_STB_MSS]   = |(d.stb & d.sre);

      d.ilock_prev  = pin_sync[1];
      // Arm once the synchronised level has settled, no false edge
      if (q.ilock_arm != TSR_ILOCK_ARM)
         d.ilock_arm = q.ilock_arm + 2'h1;

      d.resp_valid = 1'b0;
      d.resp_data  = 8'h00;
      if (accepted)
      begin
         case (cmd_code_in)
            TSR_CMD_ESR_Q:
            begin
               d.resp_valid = 1'b1;
               d.resp_data  = q.esr;
            end
            TSR_CMD_SRE_Q:
            begin
               d.resp_valid = 1'b1;
               d.resp_data  = q.sre;
            end
            TSR_CMD_STB_Q:
            begin
               d.resp_valid = 1'b1;
               d.resp_data  = q.stb;
            end
            TSR_CMD_PROT_Q:
            begin
               d.resp_valid = 1'b1;
               d.resp_data  = q.prot;
            end
            TSR_CMD_FAIL_Q:
            begin
               d.resp_valid = 1'b1;
               d.resp_data  = q.fail;
            end
            TSR_CMD_BAD_Q:
            begin
               d.resp_valid = 1'b1;
               d.resp_data  = q.bad;
            end
            TSR_CMD_ERR_Q:
            begin
               d.resp_valid = 1'b1;
               d.resp_data  = q.err;
            end
            default:
            begin
               d.resp_valid = 1'b0;
            end
         endcase
      end

      d.reject = rejected;
      // [R20] Buffer flush pulse
      d.flush  = accepted && (cmd_code_in == TSR_CMD_FLUSH);
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         q             <= '0;
         q.prot        <= TSR_FLAGS_RST;
         q.fail        <= TSR_FLAGS_RST;
         q.bad         <= TSR_FLAGS_RST;
         q.err         <= TSR_FLAGS_RST;
         q.esr         <= TSR_FLAGS_RST;
         q.sre         <= TSR_SRE_RST;
      end
      else
         q <= d;
   end

   assign protection_flags_out    = q.prot;
   assign judgment_fail_flags_out = q.fail;
   assign bad_setting_flags_out   = q.bad;
   assign command_error_flags_out = q.err;
   assign event_status_out        = q.esr;
   assign srq_enable_out          = q.sre;
   assign status_byte_out         = q.stb;
   assign resp_valid_out          = q.resp_valid;
   assign resp_data_out           = q.resp_data;
   assign run_state_reject_out    = q.reject;
   assign input_buffer_flush_out  = q.flush;

endmodule : tsr_status_regs

/* tsr_pkg.sv */
package tsr_pkg;

   // Register width shared by all flag registers
   localparam int unsigned TSR_REG_W = 8;

   // Protection flag positions
   localparam int unsigned TSR_PROT_AMP_DEV  = 5;
   localparam int unsigned TSR_PROT_ILOCK    = 4;
   localparam int unsigned TSR_PROT_CLAMP    = 3;
   localparam int unsigned TSR_PROT_OVERLOAD = 2;
   localparam int unsigned TSR_PROT_HEAT_TMR = 1;
   localparam int unsigned TSR_PROT_TEMP     = 0;

   // Judgment fail flag positions
   localparam int unsigned TSR_FAIL_UPPER = 2;
   localparam int unsigned TSR_FAIL_LOWER = 1;

   // Bad setting flag positions
   localparam int unsigned TSR_BAD_OHMS    = 3;
   localparam int unsigned TSR_BAD_POWER   = 2;
   localparam int unsigned TSR_BAD_LOW_UP  = 1;
   localparam int unsigned TSR_BAD_VOLTAGE = 0;

   // Command error flag positions
   localparam int unsigned TSR_ERR_INVALID = 3;
   localparam int unsigned TSR_ERR_RANGE   = 2;
   localparam int unsigned TSR_ERR_DATA    = 1;
   localparam int unsigned TSR_ERR_SYNTAX  = 0;

   // Event status positions
   localparam int unsigned TSR_ESR_FAULT  = 5;
   localparam int unsigned TSR_ESR_REJECT = 4;

   // Status byte positions
   localparam int unsigned TSR_STB_MSS = 6;
   localparam int unsigned TSR_STB_ESB = 5;
   localparam int unsigned TSR_STB_DSB = 4;

   // Values after reset
   localparam logic [7:0] TSR_FLAGS_RST = 8'h00;
   localparam logic [7:0] TSR_SRE_RST   = 8'h00;

   // Edges after release before interlock change detection starts
   localparam logic [1:0] TSR_ILOCK_ARM = 2'h3;

   // Memo line limits
   localparam logic [1:0] TSR_MEMO_LINE_MIN = 2'h1;
   localparam logic [1:0] TSR_MEMO_LINE_MAX = 2'h3;
   localparam int unsigned TSR_MEMO_LEN     = 20;
   localparam logic [7:0] TSR_CHAR_MIN      = 8'h20;
   localparam logic [7:0] TSR_CHAR_MAX      = 8'h7e;
   localparam logic [7:0] TSR_CHAR_DQUOTE   = 8'h22;
   localparam logic [7:0] TSR_CHAR_SQUOTE   = 8'h27;
   localparam logic [7:0] TSR_CHAR_COMMA    = 8'h2c;
   localparam logic [7:0] TSR_CHAR_AT       = 8'h40;

   // Decoded commands delivered by the message parser
   typedef enum logic [3:0] {
      TSR_CMD_CLS,
      TSR_CMD_ESR_Q,
      TSR_CMD_SRE_W,
      TSR_CMD_SRE_Q,
      TSR_CMD_STB_Q,
      TSR_CMD_FLUSH,
      TSR_CMD_MEMO_SEL,
      TSR_CMD_MEMO_CHAR,
      TSR_CMD_PROT_Q,
      TSR_CMD_FAIL_Q,
      TSR_CMD_BAD_Q,
      TSR_CMD_ERR_Q,
      TSR_CMD_OTHER_SET,
      TSR_CMD_OTHER_Q
   } tsr_cmd_t;

endpackage : tsr_pkg

/* tsr_sync.sv */
`timescale 1ns/1ps
module tsr_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   import tsr_pkg::*;

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] safe;
   } tsr_sync_state_t;

   tsr_sync_state_t s_q;
   tsr_sync_state_t s_d;

   always_comb
   begin
      s_d.meta = async_in;
      s_d.safe = s_q.meta;
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign sync_out = s_q.safe;

endmodule : tsr_sync

/* tsr_memo_check.sv */
`timescale 1ns/1ps
module tsr_memo_check (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   // Line selection and characters, already accepted
   input  wire logic       sel_in,
   input  wire logic       char_in,
   input  wire logic [7:0] data_in,
   // Error pulses
   output logic            range_err_out,
   output logic            data_err_out
);
   import tsr_pkg::*;

   typedef struct packed {
      logic       open;
      logic [4:0] count;
      logic       range_err;
      logic       data_err;
   } tsr_memo_state_t;

   tsr_memo_state_t m_q;
   tsr_memo_state_t m_d;

   function automatic logic tsr_char_ok(input logic [7:0] c);
      tsr_char_ok = (c >= TSR_CHAR_MIN) && (c <= TSR_CHAR_MAX) &&
                    (c != TSR_CHAR_DQUOTE) && (c != TSR_CHAR_SQUOTE) &&
                    (c != TSR_CHAR_COMMA) && (c != TSR_CHAR_AT);
   endfunction : tsr_char_ok

   always_comb
   begin
      m_d           = m_q;
      m_d.range_err = 1'b0;
      m_d.data_err  = 1'b0;
      // [R22] Memo line checks
      if (sel_in)
      begin
         m_d.count = 5'h00;
         m_d.open  = (data_in[7:2] == 6'h00) &&
                     (data_in[1:0] >= TSR_MEMO_LINE_MIN) &&
                     (data_in[1:0] <= TSR_MEMO_LINE_MAX);
         m_d.range_err = !m_d.open;
      end
      else if (char_in)
      begin
         if (!m_q.open)
            m_d.range_err = 1'b1;
         else if (!tsr_char_ok(data_in) ||
                  (m_q.count >= 5'(TSR_MEMO_LEN)))
            m_d.data_err = 1'b1;
         else
            m_d.count = m_q.count + 5'h01;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         m_q <= '0;
      else
         m_q <= m_d;
   end

   assign range_err_out = m_q.range_err;
   assign data_err_out  = m_q.data_err;

endmodule : tsr_memo_check

/* tsr_host_model.sv */
`timescale 1ns/1ps
module tsr_host_model (
   // Clock
   input  wire logic        clk_in,
   // Decoded command toward the device
   output logic             cmd_valid_out,
   output tsr_pkg::tsr_cmd_t cmd_code_out,
   output logic [7:0]       cmd_data_out
);
   import tsr_pkg::*;
   initial
   begin
      cmd_valid_out = 1'b0;
      cmd_code_out  = TSR_CMD_OTHER_Q;
      cmd_data_out  = 8'h00;
   end
   task automatic send(input tsr_cmd_t c, input logic [7:0] d);
      @(posedge clk_in);
      cmd_valid_out <= 1'b1;
      cmd_code_out  <= c;
      cmd_data_out  <= d;
      @(posedge clk_in);
      cmd_valid_out <= 1'b0;
      cmd_data_out  <= ~d;
   endtask : send
endmodule : tsr_host_model

/* tsr_status_monitor.sv */
`timescale 1ns/1ps
module tsr_status_monitor (
   // Clock and reset
   input wire logic              clk_in,
   input wire logic              rstn_in,
   // Pins
   input wire logic              output_amp_deviation_in,
   input wire logic              voltage_clamp_in,
   input wire logic              upper_fail_in,
   input wire logic              lower_fail_in,
   // Commands and faults
   input wire logic              cmd_valid_in,
   input wire tsr_pkg::tsr_cmd_t cmd_code_in,
   input wire logic [7:0]        cmd_data_in,
   input wire logic              header_err_in,
   // Registers and pulses
   input wire logic [7:0]        protection_flags_out,
   input wire logic [7:0]        judgment_fail_flags_out,
   input wire logic [7:0]        bad_setting_flags_out,
   input wire logic [7:0]        command_error_flags_out,
   input wire logic [7:0]        event_status_out,
   input wire logic [7:0]        srq_enable_out,
   input wire logic              resp_valid_out,
   input wire logic [7:0]        resp_data_out,
   input wire logic              run_state_reject_out,
   input wire logic              input_buffer_flush_out
);
   import tsr_pkg::*;
   logic [3:0] fail_hist_q;
   logic       is_cls;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   assign is_cls = cmd_valid_in && cmd_code_in == TSR_CMD_CLS;
   // Recent fail pin activity, which may still be in flight
   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
         fail_hist_q <= 4'h0;
      else
         fail_hist_q <= {fail_hist_q[2:0], upper_fail_in | lower_fail_in};
   a_amp_flag: assert property (
      output_amp_deviation_in [*4] |=> protection_flags_out[5])
      else $error("amp deviation flag not set");
   a_clamp_flag: assert property (
      voltage_clamp_in [*4] |=> protection_flags_out[3])
      else $error("clamp flag not set");
   a_syntax_flag: assert property (
      header_err_in |=> command_error_flags_out[0] && event_status_out[5])
      else $error("header fault not flagged");
   a_reject_marks: assert property (
      run_state_reject_out |-> command_error_flags_out[3] && event_status_out[4])
      else $error("refusal not flagged");
   a_reject_cause: assert property (
      run_state_reject_out |-> $past(cmd_valid_in) && $past(cmd_code_in) inside
      {TSR_CMD_SRE_W, TSR_CMD_MEMO_SEL, TSR_CMD_MEMO_CHAR, TSR_CMD_OTHER_SET})
      else $error("refusal of an always accepted command");
   a_flush_pulse: assert property (
      cmd_valid_in && cmd_code_in == TSR_CMD_FLUSH |=> input_buffer_flush_out)
      else $error("flush not accepted");
   a_esr_answer: assert property (
      cmd_valid_in && cmd_code_in == TSR_CMD_ESR_Q
      |=> resp_valid_out && resp_data_out == $past(event_status_out))
      else $error("event status answer wrong");
   a_sre_write: assert property (
      $past(cmd_valid_in) && $past(cmd_code_in) == TSR_CMD_SRE_W &&
      !run_state_reject_out |-> srq_enable_out == $past(cmd_data_in))
      else $error("enable write lost");
   a_cls_clears: assert property (
      is_cls && fail_hist_q == 4'h0 |=> judgment_fail_flags_out == 8'h00)
      else $error("clear status left fail flags");
   a_unused_zero: assert property (
      (protection_flags_out & 8'hc0) == 8'h00 &&
      (judgment_fail_flags_out & 8'hf9) == 8'h00 &&
      ((bad_setting_flags_out | command_error_flags_out) & 8'hf0) == 8'h00)
      else $error("unused flag bit set");
   a_flag_sticky: assert property (
      !is_cls |=> ($past(protection_flags_out) & ~protection_flags_out) == 8'h00
      && ($past(command_error_flags_out) & ~command_error_flags_out) == 8'h00)
      else $error("flag dropped without clear");
endmodule : tsr_status_monitor

bind tsr_status_regs tsr_status_monitor i_mon (.clk_in, .rstn_in,
   .output_amp_deviation_in, .voltage_clamp_in, .upper_fail_in,
   .lower_fail_in, .cmd_valid_in, .cmd_code_in, .cmd_data_in, .header_err_in,
   .protection_flags_out, .judgment_fail_flags_out, .bad_setting_flags_out,
   .command_error_flags_out, .event_status_out, .srq_enable_out,
   .resp_valid_out, .resp_data_out, .run_state_reject_out,
   .input_buffer_flush_out);

/* tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
   n_mismatch++; $display("ERROR %s exp %h got %h", nm, e, s); end end
module tb;
   import tsr_pkg::*;
   logic        clk_in  = 1'b0;
   logic        rstn_in = 1'b0;
   logic [11:0] pin_q   = 12'h000;
   logic [1:0]  st_q    = 2'h0;
   logic [2:0]  perr_q  = 3'h0;
   logic        cmd_v, rv, rej, fl;
   tsr_cmd_t    cmd_c;
   logic [7:0]  cmd_d, prot, fail, bad, err, esr, srq, stb, rd;
   int          n_mismatch  = 0;
   int          checks_done = 0;
   tsr_cmd_t    qc[3] = '{TSR_CMD_PROT_Q, TSR_CMD_FAIL_Q, TSR_CMD_BAD_Q};
   logic [7:0]  qe[3] = '{8'h3f, 8'h06, 8'h0f};
   tsr_cmd_t    rc[4] = '{TSR_CMD_SRE_W, TSR_CMD_MEMO_SEL,
                          TSR_CMD_MEMO_CHAR, TSR_CMD_OTHER_SET};
   // Memo cases: line, character, count, expected error flags
   logic [31:0] mt[10] = '{32'h00200104, 32'h04200104, 32'h01201400,
      32'h037e1502, 32'h02220102, 32'h02270102, 32'h022c0102,
      32'h02400102, 32'h021f0102, 32'h027f0102};

   always #12.5 clk_in = ~clk_in;

   tsr_host_model i_host (.clk_in, .cmd_valid_out(cmd_v),
      .cmd_code_out(cmd_c), .cmd_data_out(cmd_d));

   tsr_status_regs i_dut (.clk_in, .rstn_in,
      .output_amp_deviation_in(pin_q[5]), .interlock_in(pin_q[4]),
      .voltage_clamp_in(pin_q[3]), .overload_trip_in(pin_q[2]),
      .heat_timer_trip_in(pin_q[1]), .internal_temp_trip_in(pin_q[0]),
      .upper_fail_in(pin_q[7]), .lower_fail_in(pin_q[6]),
      .ohms_range_exceeded_in(pin_q[11]), .power_limit_exceeded_in(pin_q[10]),
      .low_above_up_in(pin_q[9]), .test_voltage_high_in(pin_q[8]),
      .testing_in(st_q[0]), .protection_active_in(st_q[1]),
      .cmd_valid_in(cmd_v), .cmd_code_in(cmd_c), .cmd_data_in(cmd_d),
      .header_err_in(perr_q[0]), .data_err_in(perr_q[1]),
      .range_err_in(perr_q[2]), .protection_flags_out(prot),
      .judgment_fail_flags_out(fail), .bad_setting_flags_out(bad),
      .command_error_flags_out(err), .event_status_out(esr),
      .srq_enable_out(srq), .status_byte_out(stb), .resp_valid_out(rv),
      .resp_data_out(rd), .run_state_reject_out(rej),
      .input_buffer_flush_out(fl));

   task automatic final_report;
      if (n_mismatch == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report

   // Sends one command and settles just after its answer edge
   task automatic cmd(input tsr_cmd_t c, input logic [7:0] d);
      i_host.send(c, d);
      #1;
   endtask : cmd

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : wait_n

   task automatic set_state(input logic [1:0] s);
      @(posedge clk_in);
      st_q <= s;
      repeat (4) @(posedge clk_in);
   endtask : set_state

   initial
   begin
      #200000;
      n_mismatch++;
      final_report();
   end

   initial
   begin
      repeat (12) @(posedge clk_in);
      rstn_in <= 1'b1;
      wait_n(1);
      `CHK("reset", 56'h0, {prot, fail, bad, err, esr, srq, stb});
      for (int i = 0; i < 12; i++)
      begin
         @(posedge clk_in);
         pin_q <= 12'h001 << i;
         wait_n(5);
         `CHK("pin flags", 12'hfff >> (11 - i),
              {bad[3:0], fail[2:1], prot[5:0]});
      end
      @(posedge clk_in);
      pin_q <= 12'h000;
      wait_n(5);
      `CHK("flags", 24'h3f060f, {prot, fail, bad});
      for (int q = 0; q < 3; q++)
      begin
         cmd(qc[q], 8'h00);
         `CHK("query", {1'b1, qe[q]}, {rv, rd});
      end
      for (int j = 0; j < 3; j++)
      begin
         @(posedge clk_in);
         perr_q <= 3'h1 << j;
      end
      @(posedge clk_in);
      perr_q <= 3'h0;
      wait_n(1);
      `CHK("faults", 16'h0720, {err, esr});
      cmd(TSR_CMD_ESR_Q, 8'h00);
      `CHK("esr read", 17'h12000, {rv, rd, esr});
      cmd(TSR_CMD_ERR_Q, 8'h00);
      `CHK("err read", 9'h107, {rv, rd});
      for (int s = 1; s < 3; s++)
      begin
         set_state(s[1:0]);
         for (int k = 0; k < 4; k++)
         begin
            cmd(rc[k], 8'h5a);
            `CHK("refuse", 9'h100, {rej, srq});
         end
         cmd(TSR_CMD_FLUSH, 8'h00);
         `CHK("flush", 2'h2, {fl, rej});
         cmd(TSR_CMD_OTHER_Q, 8'h00);
         `CHK("query ok", 2'h0, {rej, rv});
      end
      `CHK("run err", 16'h0f10, {err, esr});
      set_state(2'h0);
      cmd(TSR_CMD_SRE_W, 8'hff);
      `CHK("sre", 17'h0ff70, {rej, srq, stb});
      cmd(TSR_CMD_SRE_Q, 8'h00);
      `CHK("sre query", 9'h1ff, {rv, rd});
      cmd(TSR_CMD_STB_Q, 8'h00);
      `CHK("stb query", 9'h170, {rv, rd});
      cmd(TSR_CMD_CLS, 8'h00);
      `CHK("cls", 48'h0, {prot, fail, bad, err, esr, stb});
      foreach (mt[m])
      begin
         cmd(TSR_CMD_MEMO_SEL, mt[m][31:24]);
         repeat (mt[m][15:8]) cmd(TSR_CMD_MEMO_CHAR, mt[m][23:16]);
         wait_n(1);
         `CHK("memo", mt[m][7:0], err);
         cmd(TSR_CMD_CLS, 8'h00);
      end
      final_report();
   end
endmodule : tb
